// ---- tdc_pkg.sv ----
// Package with register map, field positions and timing constants.
package tdc_pkg;

   localparam int TDC_ADDR_W = 10;
   localparam int TDC_DATA_W = 32;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] TDC_IDX_RUN_FLAG = 8'h88;
   localparam logic [7:0] TDC_IDX_MODE = 8'h89;
   localparam logic [7:0] TDC_IDX_T0_LOW = 8'h8a;
   localparam logic [7:0] TDC_IDX_T1_LOW = 8'h8b;
   localparam logic [7:0] TDC_IDX_T0_HIGH = 8'h8c;
   localparam logic [7:0] TDC_IDX_T1_HIGH = 8'h8d;
   localparam logic [7:0] TDC_IDX_IRQ_EN = 8'ha8;
   localparam logic [7:0] TDC_IDX_PRESCALE = 8'he7;

   // Run and flag register fields.
   localparam int TDC_BIT_T1_FLAG = 7;
   localparam int TDC_BIT_T1_RUN = 6;
   localparam int TDC_BIT_T0_FLAG = 5;
   localparam int TDC_BIT_T0_RUN = 4;

   // Mode register fields.
   localparam int TDC_BIT_T1_GATE = 7;
   localparam int TDC_BIT_T1_CSEL = 6;
   localparam int TDC_POS_T1_MODE = 4;
   localparam int TDC_BIT_T0_GATE = 3;
   localparam int TDC_BIT_T0_CSEL = 2;
   localparam int TDC_POS_T0_MODE = 0;

   // Interrupt enable register fields.
   localparam int TDC_BIT_GLOBAL_EN = 7;
   localparam int TDC_BIT_T1_IEN = 3;
   localparam int TDC_BIT_T0_IEN = 1;

   // Prescale register fields.
   localparam int TDC_POS_T0_RATE = 4;
   localparam int TDC_POS_T1_RATE = 0;

   // Reset values.
   localparam logic [7:0] TDC_RST_BYTE = 8'h00;
   localparam logic [2:0] TDC_RST_RATE = 3'h0;
   localparam logic [1:0] TDC_RST_MODE = 2'h0;

   // Timing: core clock divided by twelve, prescaler range of 128.
   localparam logic [3:0] TDC_CPU_DIV = 4'hc;
   localparam logic [7:0] TDC_PRE_MAX_DIV = 8'h80;

   // Mode field codes.
   typedef enum logic [1:0] {
      TDC_MODE_13BIT,
      TDC_MODE_16BIT,
      TDC_MODE_RELOAD,
      TDC_MODE_SPLIT
   } tdc_mode_t;

   // Bus handshake states.
   typedef enum logic {
      TDC_BUS_IDLE,
      TDC_BUS_ANSWER
   } tdc_bus_t;

endpackage

// ---- tdc_prescaler.sv ----
// Oscillator prescaler producing a one-cycle count enable.
`timescale 1ns/100ps
module tdc_prescaler
   import tdc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic osc_tick,
   input wire logic [2:0] rate,
   output logic tick_r
);

   logic [6:0] cnt_r;
   logic [7:0] div;
   logic [6:0] last;

   // Code 000 divides by 128, each step halves, code 111 divides by 1.
   assign div = TDC_PRE_MAX_DIV >> rate;
   assign last = 7'(div - 8'h01);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 7'h00;
         tick_r <= 1'b0;
      end else if (osc_tick) begin
         // A change to a faster rate mid-count ends the current period early.
         if (cnt_r >= last) begin
            cnt_r <= 7'h00;
            tick_r <= 1'b1;
         end else begin
            cnt_r <= 7'(cnt_r + 7'h01);
            tick_r <= 1'b0;
         end
      end else begin
         tick_r <= 1'b0;
      end
   end

endmodule // tdc_prescaler

// ---- tdc_timer_pair.sv ----
// Two up-counting timers with four modes behind an Avalon-MM slave.
//
// Operation
// - Mode 0 counts thirteen bits, low five only.
// - Mode 0 flags overflow at 0xff1f wrap.
// - Flags software accessible; enabled flags request interrupts.
// - Mode 1 sixteen-bit count, flag at wrap.
// - Mode 2 low byte reloads from high byte.
// - Mode 3 splits timer 0; high uses cpu/12.
// - Mode 3 pin gating affects only low byte.
// - Mode 3 high byte uses timer 1 run/flag.
// - Timer 0 mode 3: timer 1 flagless.
// - Flags clear on service or software write.
// - Three-bit prescaler: 128 down to 1.
// - Clock select: cpu/12 or prescaled oscillator.
// - Gate bit lets external pin pause count.
// - Mode codes 13, 16, reload, split/reserved.
// - Mode register layout; all bits reset zero.
// - Four counter bytes read/write, reset zero.
// - Run bits start and stop each timer.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
module tdc_timer_pair
   import tdc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [TDC_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [TDC_DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [TDC_DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic osc_tick,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic t0_irq_ack,
   input wire logic t1_irq_ack,
   output logic t0_irq_req,
   output logic t1_irq_req,
   output logic global_irq_enable
);

   // Bus slave state.
   tdc_bus_t bus_r;
   logic [TDC_DATA_W-1:0] readdata_r;
   logic waitrequest_r;

   // Software-visible state.
   logic t0_overflow_flag_r;
   logic t1_overflow_flag_r;
   logic t0_run_r;
   logic t1_run_r;
   logic t0_pin_gate_r;
   logic t1_pin_gate_r;
   logic t0_clock_select_r;
   logic t1_clock_select_r;
   logic [1:0] t0_mode_field_r;
   logic [1:0] t1_mode_field_r;
   logic [2:0] t0_prescale_r;
   logic [2:0] t1_prescale_r;
   logic t0_irq_enable_r;
   logic t1_irq_enable_r;
   logic global_irq_enable_r;
   logic [7:0] t0_low_byte_r;
   logic [7:0] t0_high_byte_r;
   logic [7:0] t1_low_byte_r;
   logic [7:0] t1_high_byte_r;
   logic t0_irq_req_r;
   logic t1_irq_req_r;

   // Clock generation.
   logic [3:0] cpu_div_r;
   logic cpu12_tick_r;
   logic t0_pre_tick;
   logic t1_pre_tick;

   // Datapath helpers.
   logic wr_acc;
   logic [7:0] wbyte;
   logic t0_tick;
   logic t1_tick;
   logic t0_en;
   logic t1_en;
   logic t0_high_en;
   logic t0_split;
   logic [16:0] t0_step;
   logic [16:0] t1_step;
   logic [8:0] t0_high_step;
   logic t0_ovf;
   logic t1_ovf;
   logic [7:0] rd_mux;

   // Returns {overflow, next high byte, next low byte} for one count.
   function automatic logic [16:0] tdc_step(input logic [1:0] mode,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
      logic [16:0] res;
      res = {1'b0, hi, lo};
      case (tdc_mode_t'(mode))
         TDC_MODE_13BIT: begin
            // Upper three low-byte bits are left untouched.
            if (lo[4:0] == 5'h1f) begin
               res = {(hi == 8'hff), 8'(hi + 8'h01), lo[7:5], 5'h00};
            end else begin
               res = {1'b0, hi, lo[7:5], 5'(lo[4:0] + 5'h01)};
            end
         end
         TDC_MODE_16BIT: begin
            res = 17'({1'b0, hi, lo} + 17'h00001);
         end
         TDC_MODE_RELOAD: begin
            if (lo == 8'hff) begin
               res = {1'b1, hi, hi};
            end else begin
               res = {1'b0, hi, 8'(lo + 8'h01)};
            end
         end
         default: begin
            res = {(lo == 8'hff), hi, 8'(lo + 8'h01)};
         end
      endcase
      return res;
   endfunction

   // Returns true when a register index is being addressed.
   function automatic logic tdc_hit(input logic [TDC_ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
      return (addr[TDC_ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   assign readdata = readdata_r;
   assign waitrequest = waitrequest_r;
   assign t0_irq_req = t0_irq_req_r;
   assign t1_irq_req = t1_irq_req_r;
   assign global_irq_enable = global_irq_enable_r;

   // ---------------------------------------------------------------
   // Avalon-MM slave with one wait state.
   // ---------------------------------------------------------------

   // Writes land on the edge at which waitrequest is seen low.
   assign wr_acc = write && !waitrequest_r && byteenable[0];
   assign wbyte = writedata[7:0];

   always_comb begin
      rd_mux = 8'h00;
      if (tdc_hit(address, TDC_IDX_RUN_FLAG)) begin
         rd_mux[TDC_BIT_T1_FLAG] = t1_overflow_flag_r;
         rd_mux[TDC_BIT_T1_RUN] = t1_run_r;
         rd_mux[TDC_BIT_T0_FLAG] = t0_overflow_flag_r;
         rd_mux[TDC_BIT_T0_RUN] = t0_run_r;
      end else if (tdc_hit(address, TDC_IDX_MODE)) begin
         rd_mux[TDC_BIT_T1_GATE] = t1_pin_gate_r;
         rd_mux[TDC_BIT_T1_CSEL] = t1_clock_select_r;
         rd_mux[TDC_POS_T1_MODE +: 2] = t1_mode_field_r;
         rd_mux[TDC_BIT_T0_GATE] = t0_pin_gate_r;
         rd_mux[TDC_BIT_T0_CSEL] = t0_clock_select_r;
         rd_mux[TDC_POS_T0_MODE +: 2] = t0_mode_field_r;
      end else if (tdc_hit(address, TDC_IDX_T0_LOW)) begin
         rd_mux = t0_low_byte_r;
      end else if (tdc_hit(address, TDC_IDX_T1_LOW)) begin
         rd_mux = t1_low_byte_r;
      end else if (tdc_hit(address, TDC_IDX_T0_HIGH)) begin
         rd_mux = t0_high_byte_r;
      end else if (tdc_hit(address, TDC_IDX_T1_HIGH)) begin
         rd_mux = t1_high_byte_r;
      end else if (tdc_hit(address, TDC_IDX_IRQ_EN)) begin
         rd_mux[TDC_BIT_GLOBAL_EN] = global_irq_enable_r;
         rd_mux[TDC_BIT_T1_IEN] = t1_irq_enable_r;
         rd_mux[TDC_BIT_T0_IEN] = t0_irq_enable_r;
      end else if (tdc_hit(address, TDC_IDX_PRESCALE)) begin
         rd_mux[TDC_POS_T0_RATE +: 3] = t0_prescale_r;
         rd_mux[TDC_POS_T1_RATE +: 3] = t1_prescale_r;
      end
   end

   // Read data is captured as waitrequest drops, so it stands on the
   // accepting edge; unmapped addresses read zero.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_r <= TDC_BUS_IDLE;
         waitrequest_r <= 1'b1;
         readdata_r <= '0;
      end else begin
         case (bus_r)
            TDC_BUS_IDLE: begin
               if (read || write) begin
                  bus_r <= TDC_BUS_ANSWER;
                  waitrequest_r <= 1'b0;
                  readdata_r <= {24'h000000, rd_mux};
               end
            end
            default: begin
               bus_r <= TDC_BUS_IDLE;
               waitrequest_r <= 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control registers.
   // ---------------------------------------------------------------

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t1_pin_gate_r <= 1'b0;
         t1_clock_select_r <= 1'b0;
         t1_mode_field_r <= TDC_RST_MODE;
         t0_pin_gate_r <= 1'b0;
         t0_clock_select_r <= 1'b0;
         t0_mode_field_r <= TDC_RST_MODE;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_MODE)) begin
         t1_pin_gate_r <= wbyte[TDC_BIT_T1_GATE];
         t1_clock_select_r <= wbyte[TDC_BIT_T1_CSEL];
         t1_mode_field_r <= wbyte[TDC_POS_T1_MODE +: 2];
         t0_pin_gate_r <= wbyte[TDC_BIT_T0_GATE];
         t0_clock_select_r <= wbyte[TDC_BIT_T0_CSEL];
         t0_mode_field_r <= wbyte[TDC_POS_T0_MODE +: 2];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_run_r <= 1'b0;
         t1_run_r <= 1'b0;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_RUN_FLAG)) begin
         t0_run_r <= wbyte[TDC_BIT_T0_RUN];
         t1_run_r <= wbyte[TDC_BIT_T1_RUN];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         global_irq_enable_r <= 1'b0;
         t1_irq_enable_r <= 1'b0;
         t0_irq_enable_r <= 1'b0;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_IRQ_EN)) begin
         global_irq_enable_r <= wbyte[TDC_BIT_GLOBAL_EN];
         t1_irq_enable_r <= wbyte[TDC_BIT_T1_IEN];
         t0_irq_enable_r <= wbyte[TDC_BIT_T0_IEN];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_prescale_r <= TDC_RST_RATE;
         t1_prescale_r <= TDC_RST_RATE;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_PRESCALE)) begin
         t0_prescale_r <= wbyte[TDC_POS_T0_RATE +: 3];
         t1_prescale_r <= wbyte[TDC_POS_T1_RATE +: 3];
      end
   end

   // ---------------------------------------------------------------
   // Count clock sources.
   // ---------------------------------------------------------------

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cpu_div_r <= 4'h0;
         cpu12_tick_r <= 1'b0;
      end else if (cpu_div_r == 4'(TDC_CPU_DIV - 4'h1)) begin
         cpu_div_r <= 4'h0;
         cpu12_tick_r <= 1'b1;
      end else begin
         cpu_div_r <= 4'(cpu_div_r + 4'h1);
         cpu12_tick_r <= 1'b0;
      end
   end

   tdc_prescaler u_t0_pre (
      .clock(clock),
      .arst_n(arst_n),
      .osc_tick(osc_tick),
      .rate(t0_prescale_r),
      .tick_r(t0_pre_tick)
   );

   tdc_prescaler u_t1_pre (
      .clock(clock),
      .arst_n(arst_n),
      .osc_tick(osc_tick),
      .rate(t1_prescale_r),
      .tick_r(t1_pre_tick)
   );

   assign t0_tick = t0_clock_select_r ? t0_pre_tick : cpu12_tick_r;
   assign t1_tick = t1_clock_select_r ? t1_pre_tick : cpu12_tick_r;

   // A gated timer only advances while its pin is high.
   assign t0_en = t0_run_r && t0_tick &&
                  (!t0_pin_gate_r || ext_irq_pin_a);
   assign t1_en = t1_run_r && t1_tick &&
                  (!t1_pin_gate_r || ext_irq_pin_b);

   // In split mode the high byte ignores gate and select entirely.
   assign t0_split = (tdc_mode_t'(t0_mode_field_r) == TDC_MODE_SPLIT);
   assign t0_high_en = t0_split && t1_run_r && cpu12_tick_r;

   assign t0_step = tdc_step(t0_mode_field_r, t0_high_byte_r, t0_low_byte_r);
   assign t1_step = tdc_step(t1_mode_field_r, t1_high_byte_r, t1_low_byte_r);
   assign t0_high_step = 9'({1'b0, t0_high_byte_r} + 9'h001);

   assign t0_ovf = t0_en && t0_step[16];
   // Timer 1 flags nothing while timer 0 is split or it is itself reserved.
   assign t1_ovf = t1_en && t1_step[16] && !t0_split &&
                   tdc_mode_t'(t1_mode_field_r) != TDC_MODE_SPLIT;

   // ---------------------------------------------------------------
   // Counter bytes; a software write in the same cycle wins.
   // ---------------------------------------------------------------

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_low_byte_r <= TDC_RST_BYTE;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_T0_LOW)) begin
         t0_low_byte_r <= wbyte;
      end else if (t0_en) begin
         t0_low_byte_r <= t0_step[7:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_high_byte_r <= TDC_RST_BYTE;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_T0_HIGH)) begin
         t0_high_byte_r <= wbyte;
      end else if (t0_high_en) begin
         t0_high_byte_r <= t0_high_step[7:0];
      end else if (t0_en && !t0_split) begin
         t0_high_byte_r <= t0_step[15:8];
      end
   end

   // Reserved mode 3 for timer 1 holds the count still.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t1_low_byte_r <= TDC_RST_BYTE;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_T1_LOW)) begin
         t1_low_byte_r <= wbyte;
      end else if (t1_en &&
                   tdc_mode_t'(t1_mode_field_r) != TDC_MODE_SPLIT) begin
         t1_low_byte_r <= t1_step[7:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t1_high_byte_r <= TDC_RST_BYTE;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_T1_HIGH)) begin
         t1_high_byte_r <= wbyte;
      end else if (t1_en &&
                   tdc_mode_t'(t1_mode_field_r) != TDC_MODE_SPLIT) begin
         t1_high_byte_r <= t1_step[15:8];
      end
   end

   // ---------------------------------------------------------------
   // Overflow flags; a setting event beats any clear in its cycle.
   // ---------------------------------------------------------------

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_overflow_flag_r <= 1'b0;
      end else if (t0_ovf) begin
         t0_overflow_flag_r <= 1'b1;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_RUN_FLAG)) begin
         t0_overflow_flag_r <= wbyte[TDC_BIT_T0_FLAG];
      end else if (t0_irq_ack) begin
         t0_overflow_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t1_overflow_flag_r <= 1'b0;
      end else if (t1_ovf || (t0_high_en && t0_high_step[8])) begin
         t1_overflow_flag_r <= 1'b1;
      end else if (wr_acc && tdc_hit(address, TDC_IDX_RUN_FLAG)) begin
         t1_overflow_flag_r <= wbyte[TDC_BIT_T1_FLAG];
      end else if (t1_irq_ack) begin
         t1_overflow_flag_r <= 1'b0;
      end
   end

   // Requests follow flags one cycle later; global enable is left to
   // the interrupt controller, which sees it on its own output.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_irq_req_r <= 1'b0;
         t1_irq_req_r <= 1'b0;
      end else begin
         t0_irq_req_r <= t0_overflow_flag_r && t0_irq_enable_r;
         t1_irq_req_r <= t1_overflow_flag_r && t1_irq_enable_r;
      end
   end

endmodule // tdc_timer_pair

// ---- tdc_timer_pair_sva.sv ----
// Checker for bus handshake and interrupt request outputs of the timer pair.
`timescale 1ns/100ps
module tdc_timer_pair_sva
   import tdc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [TDC_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [TDC_DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [TDC_DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic osc_tick,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic t0_irq_ack,
   input wire logic t1_irq_ack,
   input wire logic t0_irq_req,
   input wire logic t1_irq_req,
   input wire logic global_irq_enable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // A request may only drop after an ack or an accepted write a few
   // cycles before, since the flag or the enable must change first.
   logic [2:0] t0_cause_r;
   logic [2:0] t1_cause_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         t0_cause_r <= 3'h0;
         t1_cause_r <= 3'h0;
      end else begin
         t0_cause_r <= {t0_cause_r[1:0], t0_irq_ack | (write & ~waitrequest)};
         t1_cause_r <= {t1_cause_r[1:0], t1_irq_ack | (write & ~waitrequest)};
      end
   end

   sequence s_request;
      (read || write) && waitrequest;
   endsequence
   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence

   chk_one_wait: assert property (s_request |=> s_answer)
      else $error("bus answer not after one wait state");
   chk_idle_wait: assert property (!(read || write) && waitrequest |=> waitrequest)
      else $error("waitrequest dropped with no request");
   chk_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
      else $error("waitrequest fell without a request");
   chk_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_rdata_hold: assert property (!$past(read || write) |-> $stable(readdata))
      else $error("read data changed without a read");
   chk_gie_write: assert property ($changed(global_irq_enable) |-> $past(write && !waitrequest))
      else $error("global enable changed without a write");
   chk_t0_req_fall: assert property ($fell(t0_irq_req) |-> (|t0_cause_r))
      else $error("timer 0 request dropped without cause");
   chk_t1_req_fall: assert property ($fell(t1_irq_req) |-> (|t1_cause_r))
      else $error("timer 1 request dropped without cause");
endmodule // tdc_timer_pair_sva

bind tdc_timer_pair tdc_timer_pair_sva u_sva (.clock(clock), .arst_n(arst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .osc_tick(osc_tick), .ext_irq_pin_a(ext_irq_pin_a),
   .ext_irq_pin_b(ext_irq_pin_b), .t0_irq_ack(t0_irq_ack),
   .t1_irq_ack(t1_irq_ack), .t0_irq_req(t0_irq_req), .t1_irq_req(t1_irq_req),
   .global_irq_enable(global_irq_enable));

// ---- tb_top.sv ----
// Self-checking bench for the dual timer block.
`timescale 1ns/100ps
module tb_top;
   import tdc_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [TDC_ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [TDC_DATA_W-1:0] writedata = '0;
   logic [3:0] byteenable = 4'h0;
   logic [TDC_DATA_W-1:0] readdata;
   logic waitrequest;
   logic osc_tick = 1'b0;
   logic pin_a = 1'b0;
   logic pin_b = 1'b0;
   logic ack0 = 1'b0;
   logic ack1 = 1'b0;
   logic req0;
   logic req1;
   logic gie;
   int mismatches = 0;
   int comparisons = 0;
   logic [31:0] rng = 32'h50;
   logic [7:0] exp_q[$];
   logic [7:0] v;

   always #10 clock = ~clock;

   tdc_timer_pair u_dut (.clock(clock), .arst_n(arst_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .osc_tick(osc_tick), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
      .t0_irq_ack(ack0), .t1_irq_ack(ack1), .t0_irq_req(req0),
      .t1_irq_req(req1), .global_irq_enable(gie));

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task give_verdict;
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // The request is held until waitrequest is seen low, then one idle edge
   // passes so that a following request never reuses the same time step.
   task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
            input logic [3:0] be);
      int n;
      address <= {idx, 2'b00};
      read <= ~wr;
      write <= wr;
      writedata <= {24'h0, d};
      byteenable <= be;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) begin
         mismatches++;
         give_verdict();
      end else begin
         read <= 1'b0;
         write <= 1'b0;
         @(posedge clock);
      end
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, 4'h1);
   endtask

   task rd(input logic [7:0] idx, input logic [7:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, idx, 8'h00, 4'hf);
   endtask

   always @(posedge clock) begin
      if (read && waitrequest === 1'b0) begin
         if (exp_q.size() == 0)
            check("unexpected read", 1, 0);
         else
            check("readdata", readdata, {24'h0, exp_q.pop_front()});
      end
   end

   task pulse(input int n);
      repeat (n) begin
         osc_tick <= 1'b1;
         @(posedge clock);
         osc_tick <= 1'b0;
         @(posedge clock);
      end
   endtask

   // Counts are driven from the oscillator tick so that the number of
   // increments is exact and independent of the divide-by-twelve phase.
   task run_case(input logic t, input logic [3:0] timer_mode_select, input logic [2:0] rate,
                 input logic pin, input logic [7:0] th, input logic [7:0] tl,
                 input int n, input logic [7:0] eth, input logic [7:0] etl,
                 input logic ef);
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] run;
      hi = t ? TDC_IDX_T1_HIGH : TDC_IDX_T0_HIGH;
      lo = t ? TDC_IDX_T1_LOW : TDC_IDX_T0_LOW;
      run = t ? 8'h40 : 8'h10;
      wr(TDC_IDX_RUN_FLAG, 8'h00);
      wr(TDC_IDX_MODE, t ? {timer_mode_select, 4'h0} : {4'h0, timer_mode_select});
      wr(TDC_IDX_PRESCALE, t ? {5'h0, rate} : {1'b0, rate, 4'h0});
      wr(hi, th);
      wr(lo, tl);
      pin_a <= pin;
      pin_b <= pin;
      wr(TDC_IDX_RUN_FLAG, run);
      pulse(n);
      repeat (4) @(posedge clock);
      check("irq request", t ? req1 : req0, ef);
      rd(TDC_IDX_RUN_FLAG, ef ? (run | (t ? 8'h80 : 8'h20)) : run);
      rd(hi, eth);
      rd(lo, etl);
      if (ef) begin
         ack0 <= ~t;
         ack1 <= t;
         @(posedge clock);
         ack0 <= 1'b0;
         ack1 <= 1'b0;
         repeat (3) @(posedge clock);
         check("acked request", t ? req1 : req0, 0);
         rd(TDC_IDX_RUN_FLAG, run);
      end
   endtask

   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      rd(TDC_IDX_MODE, 8'h00);
      rd(TDC_IDX_IRQ_EN, 8'h00);
      rd(TDC_IDX_RUN_FLAG, 8'h00);
      rd(TDC_IDX_T0_LOW, 8'h00);
      rd(TDC_IDX_T1_LOW, 8'h00);
      rd(TDC_IDX_T0_HIGH, 8'h00);
      rd(TDC_IDX_T1_HIGH, 8'h00);
      rd(TDC_IDX_PRESCALE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 8'(xs());
         wr(TDC_IDX_MODE, v);
         rd(TDC_IDX_MODE, v);
         wr(TDC_IDX_T0_HIGH, ~v);
         rd(TDC_IDX_T0_HIGH, ~v);
         wr(TDC_IDX_T1_LOW, v);
         rd(TDC_IDX_T1_LOW, v);
         wr(TDC_IDX_PRESCALE, v);
         rd(TDC_IDX_PRESCALE, v & 8'h77);
         wr(TDC_IDX_IRQ_EN, v);
         rd(TDC_IDX_IRQ_EN, v & 8'h8a);
         wr(TDC_IDX_RUN_FLAG, v & 8'ha0);
         rd(TDC_IDX_RUN_FLAG, v & 8'ha0);
      end
      bus(1'b1, TDC_IDX_T1_LOW, ~v, 4'he);
      rd(TDC_IDX_T1_LOW, v);
      bus(1'b1, 8'h90, 8'hff, 4'h1);
      rd(8'h90, 8'h00);
      wr(TDC_IDX_IRQ_EN, 8'h8a);
      check("global enable", gie, 1);
      run_case(0, 4'h4, 3'h7, 0, 8'hfe, 8'h1e, 2, 8'hff, 8'h00, 0);
      run_case(0, 4'h4, 3'h7, 0, 8'hff, 8'h1d, 3, 8'h00, 8'h00, 1);
      run_case(0, 4'h5, 3'h7, 0, 8'h12, 8'hff, 1, 8'h13, 8'h00, 0);
      run_case(0, 4'h5, 3'h7, 0, 8'hff, 8'hfe, 2, 8'h00, 8'h00, 1);
      run_case(0, 4'h6, 3'h7, 0, 8'h40, 8'hfe, 2, 8'h40, 8'h40, 1);
      run_case(0, 4'h6, 3'h7, 0, 8'h40, 8'hfe, 3, 8'h40, 8'h41, 1);
      run_case(0, 4'hd, 3'h7, 0, 8'h00, 8'h05, 3, 8'h00, 8'h05, 0);
      run_case(0, 4'hd, 3'h7, 1, 8'h00, 8'h05, 3, 8'h00, 8'h08, 0);
      run_case(1, 4'h5, 3'h7, 1, 8'hff, 8'hff, 1, 8'h00, 8'h00, 1);
      run_case(1, 4'hd, 3'h7, 0, 8'h00, 8'h05, 3, 8'h00, 8'h05, 0);
      run_case(1, 4'h4, 3'h7, 0, 8'hff, 8'h1f, 1, 8'h00, 8'h00, 1);
      run_case(1, 4'h5, 3'h6, 0, 8'h00, 8'h00, 4, 8'h00, 8'h02, 0);
      for (int r = 0; r < 8; r++)
         run_case(0, 4'h5, r[2:0], 0, 8'h00, 8'h00, 2 << (7 - r), 8'h00, 8'h02, 0);
      // Split mode: low byte gated off, timer 1 wraps without a flag.
      wr(TDC_IDX_RUN_FLAG, 8'h00);
      wr(TDC_IDX_MODE, 8'h5f);
      wr(TDC_IDX_PRESCALE, 8'h77);
      wr(TDC_IDX_T0_LOW, 8'hff);
      wr(TDC_IDX_T0_HIGH, 8'h00);
      wr(TDC_IDX_T1_LOW, 8'hff);
      wr(TDC_IDX_T1_HIGH, 8'hff);
      pin_a <= 1'b0;
      wr(TDC_IDX_RUN_FLAG, 8'h50);
      pulse(2);
      repeat (4) @(posedge clock);
      rd(TDC_IDX_RUN_FLAG, 8'h50);
      rd(TDC_IDX_T0_LOW, 8'hff);
      rd(TDC_IDX_T1_LOW, 8'h01);
      rd(TDC_IDX_T1_HIGH, 8'h00);
      wr(TDC_IDX_T0_HIGH, 8'hff);
      repeat (16) @(posedge clock);
      rd(TDC_IDX_RUN_FLAG, 8'hd0);
      pin_a <= 1'b1;
      pulse(1);
      repeat (4) @(posedge clock);
      rd(TDC_IDX_RUN_FLAG, 8'hf0);
      check("split low request", req0, 1);
      check("split high request", req1, 1);
      // Reserved mode for timer 1 holds its count and raises no flag.
      wr(TDC_IDX_MODE, 8'h70);
      wr(TDC_IDX_T1_LOW, 8'hff);
      wr(TDC_IDX_RUN_FLAG, 8'h40);
      pulse(2);
      repeat (4) @(posedge clock);
      rd(TDC_IDX_T1_LOW, 8'hff);
      rd(TDC_IDX_RUN_FLAG, 8'h40);
      give_verdict();
   end

   initial begin
      #1200000;
      mismatches++;
      give_verdict();
   end
endmodule // tb_top
